// [dv/counter_array_timebase_sva.sv]
`timescale 1ns/10ps
module counter_array_timebase_sva
    import counter_array_pkg::*;
#(
    parameter int unsigned COUNT_W = COUNT_W_DEFAULT,
    parameter int unsigned NUM_MODULES = NUM_MODULES_DEFAULT
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic idleMode,
    input wire logic doubleSpeedMode,
    input wire logic timer0Overflow,
    input wire logic externalCountInput,
    input wire logic [NUM_MODULES-1:0] moduleEvent,
    input wire logic [COUNT_W-1:0] counterValue,
    input wire logic watchdogEnable,
    input wire logic irq
);
    // ****************************************
    // Shadow of written control state
    // ****************************************
    logic acc, wr, unmapped, halt, runR, runNxt;
    logic [7:0] modeR, modeNxt, maskR, maskNxt;
    logic [3:0] haltCntR, haltCntNxt, liveCntR, liveCntNxt;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign unmapped = !(paddr inside {CONTROL_ADDR, MODE_ADDR, INT_STATUS_ADDR, INT_MASK_ADDR, COUNT_ADDR});
    assign halt = !runR || (idleMode && modeR[MODE_IDLE_STOP_BIT]);
    always_comb begin
        runNxt = (wr && paddr == CONTROL_ADDR) ? pwdata[CTL_RUN_BIT] : runR;
        modeNxt = (wr && paddr == MODE_ADDR) ? pwdata[7:0] : modeR;
        maskNxt = (wr && paddr == INT_MASK_ADDR) ? pwdata[7:0] : maskR;
        haltCntNxt = !halt ? 4'h0 : ((haltCntR == 4'hF) ? haltCntR : haltCntR + 4'h1);
        liveCntNxt = (halt || wr) ? 4'h0 : ((liveCntR == 4'hF) ? liveCntR : liveCntR + 4'h1);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {runR, modeR, maskR, haltCntR, liveCntR} <= '0;
        end else begin
            {runR, modeR, maskR, haltCntR, liveCntR} <= {runNxt, modeNxt, maskNxt, haltCntNxt, liveCntNxt};
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_count_step: assert property (counterValue != $past(counterValue) |-> counterValue == COUNT_W'($past(counterValue) + 1)) else $error("count moved by other than one");
    a_halt_freezes: assert property (halt && haltCntR >= 4'h8 |-> $stable(counterValue)) else $error("counter moved while halted");
    a_timer0_counts: assert property (timer0Overflow && !halt && liveCntR >= 4'h4 && modeR[2:1] == 2'b10 |-> ##[1:4] counterValue != $past(counterValue)) else $error("timer0 pulse not counted");
    a_wdt_follows: assert property (wr && paddr == MODE_ADDR |=> watchdogEnable == $past(pwdata[MODE_WDT_BIT])) else $error("watchdog enable wrong");
    a_slverr_map: assert property (acc |-> pslverr == unmapped) else $error("slave error wrong");
    a_read_zero: assert property (acc && !pwrite && unmapped |-> prdata == '0) else $error("unmapped read not zero");
    a_upper_zero: assert property (acc && !pwrite && paddr != COUNT_ADDR |-> prdata[31:8] == '0) else $error("upper read bits set");
    a_ovf_irq: assert property ($past(counterValue) == '1 && counterValue == '0 && maskR[7] && modeR[0] |-> ##[0:1] irq) else $error("no overflow interrupt");
    a_irq_enabled: assert property (irq |-> (maskR[7] && modeR[MODE_OVF_IRQ_BIT]) || (|maskR[4:0])) else $error("interrupt without enable");
    a_module_irq: assert property (moduleEvent[0] && maskR[0] |-> ##[0:2] irq) else $error("module event lost");
    c_run: cover property (wr && paddr == CONTROL_ADDR && pwdata[CTL_RUN_BIT]);
    c_wrap: cover property ($past(counterValue) == '1 && counterValue == '0);
    c_idle: cover property (runR && idleMode && modeR[MODE_IDLE_STOP_BIT]);
endmodule

// [dv/test_counter_array_timebase.sv]
`timescale 1ns/10ps
module test_counter_array_timebase;
    import counter_array_pkg::*;
    localparam int unsigned CW = 8;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
    logic idleMode = 1'b0, doubleSpeedMode = 1'b0, timer0Overflow = 1'b0, externalCountInput = 1'b1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [4:0] moduleEvent = '0;
    logic pready, pslverr, watchdogEnable, irq;
    logic [CW-1:0] counterValue, v;
    int n_fail = 0, n_compared = 0;
    counter_array_timebase #(.COUNT_W(CW), .NUM_MODULES(5)) i_counter_array_timebase (.clk(clk), .rst_n(rst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .idleMode(idleMode), .doubleSpeedMode(doubleSpeedMode),
        .timer0Overflow(timer0Overflow), .externalCountInput(externalCountInput), .moduleEvent(moduleEvent),
        .counterValue(counterValue), .watchdogEnable(watchdogEnable), .irq(irq));
    initial begin
        forever #10 clk = ~clk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task give_verdict();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task fail_out(input string what);
        n_fail++;
        $display("MISMATCH %0t timeout %s", $time, what);
        give_verdict();
    endtask
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) fail_out("pready");
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wait_change(output int n);
        logic [CW-1:0] s;
        s = counterValue;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (counterValue === s && n < 100);
        if (n >= 100) fail_out("count");
    endtask
    task pulse_t0();
        @(posedge clk) timer0Overflow <= 1'b1;
        @(posedge clk) timer0Overflow <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset_bus();
        logic [11:0] ra [4];
        logic [7:0] im [4];
        ra = '{CONTROL_ADDR, MODE_ADDR, INT_STATUS_ADDR, INT_MASK_ADDR};
        im = '{CONTROL_IMPL, MODE_IMPL, INT_IMPL, INT_IMPL};
        for (int i = 0; i < 4; i++) begin
            xfer(ra[i], 1'b0, 32'h0);
            check(rd & {24'h0, im[i]}, 32'h0, "reset value");
        end
        xfer(12'h000, 1'b1, 32'hFF);
        check(slv, 1'b1, "unmapped error");
        xfer(12'h000, 1'b0, 32'h0);
        check(rd, 32'h0, "unmapped read");
        xfer(MODE_ADDR, 1'b1, 32'h40);
        @(negedge clk) check(watchdogEnable, 1'b1, "watchdog on");
        xfer(MODE_ADDR, 1'b1, 32'h00);
        @(negedge clk) check(watchdogEnable, 1'b0, "watchdog off");
    endtask
    task t_timer0();
        xfer(MODE_ADDR, 1'b1, 32'h04);
        xfer(CONTROL_ADDR, 1'b1, 32'h40);
        repeat (4) @(posedge clk);
        v = counterValue;
        repeat (5) pulse_t0();
        @(negedge clk) check(counterValue, CW'(v + 5), "timer0 count");
        xfer(CONTROL_ADDR, 1'b1, 32'h00);
        repeat (4) @(posedge clk);
        v = counterValue;
        repeat (3) pulse_t0();
        @(negedge clk) check(counterValue, v, "stopped count");
        xfer(COUNT_ADDR, 1'b0, 32'h0);
        check(rd, {12'h000, 1'b0, ST_STOPPED, 8'h00, v}, "count readback");
    endtask
    task t_prescale();
        int per [4];
        int n;
        per = '{12, 6, 4, 2};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) doubleSpeedMode <= i[0];
            xfer(MODE_ADDR, 1'b1, 32'((i / 2) * 2));
            xfer(CONTROL_ADDR, 1'b1, 32'h40);
            wait_change(n);
            wait_change(n);
            check(n, per[i], "prescale period");
            xfer(CONTROL_ADDR, 1'b1, 32'h00);
        end
    endtask
    task t_idle();
        xfer(MODE_ADDR, 1'b1, 32'h82);
        xfer(CONTROL_ADDR, 1'b1, 32'h40);
        @(posedge clk) idleMode <= 1'b1;
        repeat (6) @(posedge clk);
        v = counterValue;
        repeat (20) @(posedge clk);
        check(counterValue, v, "idle held");
        xfer(MODE_ADDR, 1'b1, 32'h02);
        repeat (20) @(posedge clk);
        check(counterValue !== v, 1'b1, "idle runs");
        idleMode <= 1'b0;
    endtask
    task t_overflow();
        int k;
        bit seen;
        xfer(INT_MASK_ADDR, 1'b1, 32'h80);
        xfer(MODE_ADDR, 1'b1, 32'h03);
        seen = 0;
        k = 0;
        while (!(seen && counterValue === '0) && k < 1500) begin
            @(negedge clk);
            k++;
            if (counterValue === '1) seen = 1;
        end
        if (k >= 1500) fail_out("wrap");
        @(negedge clk) check(irq, 1'b1, "overflow irq");
        xfer(CONTROL_ADDR, 1'b0, 32'h0);
        check(rd[7], 1'b1, "overflow flag");
        xfer(MODE_ADDR, 1'b1, 32'h02);
        @(negedge clk) check(irq, 1'b0, "irq gated");
        xfer(INT_STATUS_ADDR, 1'b1, 32'h80);
        xfer(CONTROL_ADDR, 1'b1, 32'h00);
        xfer(CONTROL_ADDR, 1'b0, 32'h0);
        check(rd[7], 1'b0, "flag cleared");
        xfer(CONTROL_ADDR, 1'b1, 32'h80);
        xfer(CONTROL_ADDR, 1'b0, 32'h0);
        check(rd[7], 1'b1, "flag set by write");
        xfer(CONTROL_ADDR, 1'b1, 32'h00);
    endtask
    task t_modules();
        logic [31:0] m;
        xfer(INT_MASK_ADDR, 1'b1, 32'h1F);
        m = '0;
        for (int n = 0; n < 5; n++) begin
            @(posedge clk) moduleEvent[n] <= 1'b1;
            @(posedge clk) moduleEvent[n] <= 1'b0;
            repeat (8) @(posedge clk);
            m[n] = 1'b1;
            xfer(CONTROL_ADDR, 1'b0, 32'h0);
            check(rd & 32'h1F, m, "module flags");
        end
        @(negedge clk) check(irq, 1'b1, "module irq");
        xfer(CONTROL_ADDR, 1'b1, 32'h00);
        xfer(CONTROL_ADDR, 1'b0, 32'h0);
        check(rd & 32'h1F, 32'h0, "flags cleared");
        xfer(INT_STATUS_ADDR, 1'b1, 32'h1F);
        @(negedge clk) check(irq, 1'b0, "irq cleared");
    endtask
    task t_external();
        xfer(MODE_ADDR, 1'b1, 32'h06);
        xfer(CONTROL_ADDR, 1'b1, 32'h40);
        repeat (8) @(posedge clk);
        v = counterValue;
        repeat (4) begin
            externalCountInput <= 1'b0;
            repeat (8) @(posedge clk);
            externalCountInput <= 1'b1;
            repeat (8) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        check(counterValue, CW'(v + 4), "external count");
        xfer(CONTROL_ADDR, 1'b1, 32'h00);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_bus();
        t_timer0();
        t_prescale();
        t_idle();
        t_overflow();
        t_modules();
        t_external();
        give_verdict();
    end
endmodule
bind counter_array_timebase counter_array_timebase_sva #(.COUNT_W(COUNT_W), .NUM_MODULES(NUM_MODULES))
    i_counter_array_timebase_sva (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .idleMode(idleMode),
    .doubleSpeedMode(doubleSpeedMode), .timer0Overflow(timer0Overflow), .externalCountInput(externalCountInput),
    .moduleEvent(moduleEvent), .counterValue(counterValue), .watchdogEnable(watchdogEnable), .irq(irq));

// [logic/count_pulse_gen.sv]
`timescale 1ns/10ps
module count_pulse_gen
    import counter_array_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    count_src_if.gen src,
    input wire logic timer0Overflow,
    input wire logic externalCountInput
);

    // ****************************************
    // Prescaler and external input capture
    // ****************************************
    logic [3:0] pre_r;
    logic [3:0] pre_nxt;
    logic eciMeta_r;
    logic eciSync_r;
    logic eciLast_r;
    logic pulse_r;
    logic pulse_nxt;
    logic [3:0] divisor;
    logic preWrap;
    logic eciFall;

    always_comb begin
        case (src.sel)
            SRC_DIV_SLOW: divisor = src.doubleSpeed ? DIV_SLOW_X2 : DIV_SLOW_STD;
            SRC_DIV_FAST: divisor = src.doubleSpeed ? DIV_FAST_X2 : DIV_FAST_STD;
            default: divisor = DIV_FAST_STD;
        endcase
        preWrap = (pre_r >= divisor - 4'h1);
        eciFall = eciLast_r & ~eciSync_r;
        if (!src.enable || preWrap) begin
            pre_nxt = 4'h0;
        end else begin
            pre_nxt = pre_r + 4'h1;
        end
        case (src.sel)
            SRC_DIV_SLOW: pulse_nxt = src.enable & preWrap;
            SRC_DIV_FAST: pulse_nxt = src.enable & preWrap;
            SRC_TIMER0: pulse_nxt = src.enable & timer0Overflow;
            SRC_EXTERNAL: pulse_nxt = src.enable & eciFall;
            default: pulse_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 4'h0;
            eciMeta_r <= 1'b0;
            eciSync_r <= 1'b0;
            eciLast_r <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            eciMeta_r <= externalCountInput;
            eciSync_r <= eciMeta_r;
            eciLast_r <= eciSync_r;
            pulse_r <= pulse_nxt;
        end
    end

    assign src.pulse = pulse_r;

endmodule

// [logic/count_src_if.sv]
`timescale 1ns/10ps
interface count_src_if;
    import counter_array_pkg::*;
    count_src_e sel;
    logic doubleSpeed;
    logic enable;
    logic pulse;

    modport ctrl (output sel, output doubleSpeed, output enable, input pulse);
    modport gen (input sel, input doubleSpeed, input enable, output pulse);
endinterface

// [logic/counter_array_pkg.sv]
package counter_array_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;
    localparam int unsigned COUNT_W_DEFAULT = 16;
    localparam int unsigned NUM_MODULES_DEFAULT = 5;
    localparam int unsigned REG_W = 8;

    // ****************************************
    // Register indices and byte addresses
    // ****************************************
    localparam logic [7:0] CONTROL_IDX = 8'hD8;
    localparam logic [7:0] MODE_IDX = 8'hD9;
    localparam logic [7:0] INT_STATUS_IDX = 8'hDA;
    localparam logic [7:0] INT_MASK_IDX = 8'hDB;
    localparam logic [7:0] COUNT_IDX = 8'hDC;
    localparam logic [11:0] CONTROL_ADDR = {2'b00, CONTROL_IDX, 2'b00};
    localparam logic [11:0] MODE_ADDR = {2'b00, MODE_IDX, 2'b00};
    localparam logic [11:0] INT_STATUS_ADDR = {2'b00, INT_STATUS_IDX, 2'b00};
    localparam logic [11:0] INT_MASK_ADDR = {2'b00, INT_MASK_IDX, 2'b00};
    localparam logic [11:0] COUNT_ADDR = {2'b00, COUNT_IDX, 2'b00};

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned CTL_OVF_BIT = 7;
    localparam int unsigned CTL_RUN_BIT = 6;
    localparam int unsigned MODE_IDLE_STOP_BIT = 7;
    localparam int unsigned MODE_WDT_BIT = 6;
    localparam int unsigned MODE_SRC_HI_BIT = 2;
    localparam int unsigned MODE_SRC_LO_BIT = 1;
    localparam int unsigned MODE_OVF_IRQ_BIT = 0;
    localparam int unsigned COUNT_STATE_LSB = 16;
    localparam int unsigned COUNT_WDT_BIT = 19;

    // ****************************************
    // Reset values and implemented-bit masks
    // ****************************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] INT_STATUS_RESET = 8'h00;
    localparam logic [7:0] INT_MASK_RESET = 8'h00;
    localparam logic [7:0] CONTROL_IMPL = 8'hDF;
    localparam logic [7:0] MODE_IMPL = 8'hC7;
    localparam logic [7:0] INT_IMPL = 8'h9F;

    // ****************************************
    // Count source select and dividers
    // ****************************************
    typedef enum logic [1:0] {
        SRC_DIV_SLOW = 2'b00,
        SRC_DIV_FAST = 2'b01,
        SRC_TIMER0 = 2'b10,
        SRC_EXTERNAL = 2'b11
    } count_src_e;

    localparam logic [3:0] DIV_SLOW_STD = 4'hC;
    localparam logic [3:0] DIV_SLOW_X2 = 4'h6;
    localparam logic [3:0] DIV_FAST_STD = 4'h4;
    localparam logic [3:0] DIV_FAST_X2 = 4'h2;

    // ****************************************
    // Counter run state
    // ****************************************
    typedef enum logic [2:0] {
        ST_STOPPED = 3'b001,
        ST_RUNNING = 3'b010,
        ST_IDLE_HELD = 3'b100
    } run_state_e;

endpackage

// [logic/counter_array_timebase.sv]
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Idle-stop bit halts counter during core idle
// - Watchdog enable bit gates module 4 watchdog
// - Source select: div12/6, div4/2, timer0, external
// - Run control bit 6 starts and stops counter
// - Overflow flag bit 7 set on rollover
// - Overflow interrupt only with overflow enable set
// - Overflow flag: hardware sets, software sets/clears
// - Control bits 0-4 are module event flags
// - Module match or capture sets its flag
// - Module flags cleared only by software
// - Unimplemented bits read undefined, here zero
module counter_array_timebase
    import counter_array_pkg::*;
#(
    parameter int unsigned COUNT_W = COUNT_W_DEFAULT,
    parameter int unsigned NUM_MODULES = NUM_MODULES_DEFAULT
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_DATA_W-1:0] pwdata,
    output logic [APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,

    input wire logic idleMode,
    input wire logic doubleSpeedMode,
    input wire logic timer0Overflow,
    input wire logic externalCountInput,
    input wire logic [NUM_MODULES-1:0] moduleEvent,

    output logic [COUNT_W-1:0] counterValue,
    output logic watchdogEnable,
    output logic irq
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    generate
        if (COUNT_W < 2 || COUNT_W > COUNT_STATE_LSB) begin : g_bad_count_w
            $error("COUNT_W must lie between 2 and 16");
        end
        if (NUM_MODULES < 1 || NUM_MODULES > NUM_MODULES_DEFAULT) begin : g_bad_modules
            $error("NUM_MODULES must lie between 1 and 5");
        end
        if (DIV_SLOW_X2 == 4'h0 || DIV_FAST_X2 == 4'h0) begin : g_bad_divisor
            $error("Prescaler divisors must be nonzero");
        end
    endgenerate

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] control_r;
    logic [7:0] control_nxt;

    logic [7:0] mode_r;
    logic [7:0] mode_nxt;

    logic [7:0] intStatus_r;
    logic [7:0] intStatus_nxt;

    logic [7:0] intMask_r;
    logic [7:0] intMask_nxt;

    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;

    run_state_e state_r;
    run_state_e state_nxt;

    logic [APB_DATA_W-1:0] prdata_r;
    logic [APB_DATA_W-1:0] prdata_nxt;

    logic setupPhase;
    logic accessPhase;
    logic writeAccess;

    logic addrMapped;
    logic writeControl;
    logic writeMode;
    logic writeIntStatus;
    logic writeIntMask;

    logic [APB_DATA_W-1:0] readData;

    logic runControlBit;
    logic overflowFlag;
    logic idleStopBit;
    logic watchdogEnableBit;
    logic overflowIrqEnable;
    logic countSourceSelHi;
    logic countSourceSelLo;
    logic [NUM_MODULES-1:0] moduleEventFlag;
    logic [NUM_MODULES-1:0] moduleFlagNxt;

    logic countStep;
    logic overflowEvent;
    logic [7:0] eventVector;
    logic [7:0] irqGate;
    logic [COUNT_W-1:0] countMax;

    count_src_if srcBus ();

    // ****************************************
    // Field views
    // ****************************************
    assign runControlBit = control_r[CTL_RUN_BIT];
    assign overflowFlag = control_r[CTL_OVF_BIT];

    assign idleStopBit = mode_r[MODE_IDLE_STOP_BIT];
    assign watchdogEnableBit = mode_r[MODE_WDT_BIT];
    assign overflowIrqEnable = mode_r[MODE_OVF_IRQ_BIT];
    assign countSourceSelHi = mode_r[MODE_SRC_HI_BIT];
    assign countSourceSelLo = mode_r[MODE_SRC_LO_BIT];
    assign moduleEventFlag = control_r[NUM_MODULES-1:0];
    assign countMax = '1;

    // ****************************************
    // APB decode
    // ****************************************
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign writeAccess = accessPhase & pwrite;

    always_comb begin
        case (paddr)
            CONTROL_ADDR: addrMapped = 1'b1;
            MODE_ADDR: addrMapped = 1'b1;
            INT_STATUS_ADDR: addrMapped = 1'b1;
            INT_MASK_ADDR: addrMapped = 1'b1;
            COUNT_ADDR: addrMapped = 1'b1;
            default: addrMapped = 1'b0;
        endcase
    end

    assign writeControl = writeAccess & (paddr == CONTROL_ADDR);
    assign writeMode = writeAccess & (paddr == MODE_ADDR);
    assign writeIntStatus = writeAccess & (paddr == INT_STATUS_ADDR);
    assign writeIntMask = writeAccess & (paddr == INT_MASK_ADDR);

    assign pready = 1'b1;
    assign pslverr = accessPhase & ~addrMapped;

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        readData = '0;
        case (paddr)
            CONTROL_ADDR: readData[7:0] = control_r & CONTROL_IMPL;
            MODE_ADDR: readData[7:0] = mode_r & MODE_IMPL;
            INT_STATUS_ADDR: readData[7:0] = intStatus_r;
            INT_MASK_ADDR: readData[7:0] = intMask_r;
            COUNT_ADDR: begin
                readData[COUNT_W-1:0] = count_r;
                readData[COUNT_STATE_LSB +: 3] = state_r;
                readData[COUNT_WDT_BIT] = watchdogEnableBit;
            end
            default: readData = '0;
        endcase
    end

    always_comb begin
        prdata_nxt = prdata_r;
        if (setupPhase && !pwrite) begin
            prdata_nxt = readData;
        end
    end

    // ****************************************
    // Count source generator
    // ****************************************
    assign srcBus.sel = count_src_e'({countSourceSelHi, countSourceSelLo});
    assign srcBus.doubleSpeed = doubleSpeedMode;
    assign srcBus.enable = (state_r == ST_RUNNING);

    count_pulse_gen i_count_pulse_gen (
        .clk(clk),
        .rst_n(rst_n),
        .src(srcBus),
        .timer0Overflow(timer0Overflow),
        .externalCountInput(externalCountInput)
    );

    // ****************************************
    // Run state
    // ****************************************
    always_comb begin
        case (state_r)
            ST_STOPPED: begin
                if (!runControlBit) begin
                    state_nxt = ST_STOPPED;
                end else if (idleMode && idleStopBit) begin
                    state_nxt = ST_IDLE_HELD;
                end else begin
                    state_nxt = ST_RUNNING;
                end
            end

            ST_RUNNING: begin
                if (!runControlBit) begin
                    state_nxt = ST_STOPPED;
                end else if (idleMode && idleStopBit) begin
                    state_nxt = ST_IDLE_HELD;
                end else begin
                    state_nxt = ST_RUNNING;
                end
            end

            ST_IDLE_HELD: begin
                if (!runControlBit) begin
                    state_nxt = ST_STOPPED;
                end else if (idleMode && idleStopBit) begin
                    state_nxt = ST_IDLE_HELD;
                end else begin
                    state_nxt = ST_RUNNING;
                end
            end

            default: state_nxt = ST_STOPPED;
        endcase
    end

    // ****************************************
    // Counter
    // ****************************************
    assign countStep = srcBus.pulse & (state_r == ST_RUNNING);
    assign overflowEvent = countStep & (count_r == countMax);

    always_comb begin
        count_nxt = count_r;
        if (countStep) begin
            count_nxt = count_r + {{(COUNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************
    // Module event flags
    // ****************************************
    genvar gi;

    generate
        for (gi = 0; gi < NUM_MODULES; gi++) begin : g_mod_flag
            // Hardware set wins over a software clear in the same cycle
            assign moduleFlagNxt[gi] = (writeControl ? pwdata[gi] : moduleEventFlag[gi])
                                       | moduleEvent[gi];
        end
    endgenerate

    // ****************************************
    // Control and mode registers
    // ****************************************
    always_comb begin
        control_nxt = control_r;
        if (writeControl) begin
            control_nxt[CTL_RUN_BIT] = pwdata[CTL_RUN_BIT];
            control_nxt[CTL_OVF_BIT] = pwdata[CTL_OVF_BIT];
        end
        if (overflowEvent) begin
            control_nxt[CTL_OVF_BIT] = 1'b1;
        end
        control_nxt[NUM_MODULES-1:0] = moduleFlagNxt;
        control_nxt = control_nxt & CONTROL_IMPL;
    end

    always_comb begin
        mode_nxt = mode_r;
        if (writeMode) begin
            mode_nxt = pwdata[7:0] & MODE_IMPL;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    always_comb begin
        eventVector = 8'h00;
        eventVector[CTL_OVF_BIT] = overflowEvent;
        eventVector[NUM_MODULES-1:0] = moduleEvent;
        irqGate = 8'h1F;
        irqGate[CTL_OVF_BIT] = overflowIrqEnable;
    end

    always_comb begin
        intStatus_nxt = intStatus_r;
        if (writeIntStatus) begin
            intStatus_nxt = intStatus_r & ~pwdata[7:0];
        end
        intStatus_nxt = (intStatus_nxt | eventVector) & INT_IMPL;
    end

    always_comb begin
        intMask_nxt = intMask_r;
        if (writeIntMask) begin
            intMask_nxt = pwdata[7:0] & INT_IMPL;
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_r <= CONTROL_RESET;
            mode_r <= MODE_RESET;
            intStatus_r <= INT_STATUS_RESET;
            intMask_r <= INT_MASK_RESET;
            count_r <= '0;
            state_r <= ST_STOPPED;
            prdata_r <= '0;
        end else begin
            control_r <= control_nxt;
            mode_r <= mode_nxt;
            intStatus_r <= intStatus_nxt;
            intMask_r <= intMask_nxt;
            count_r <= count_nxt;
            state_r <= state_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_r;
    assign counterValue = count_r;
    assign watchdogEnable = watchdogEnableBit;
    assign irq = |(intStatus_r & intMask_r & irqGate);

endmodule
